// *** inc/pmlc_pkg.sv ***
// package: offsets, fields, reset values and counts of the loop control
// assumes: 200 MHz sys_clk, plain register port with one-cycle read data
package pmlc_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [3:0] PMLC_CTRL_OFF  = 4'h0; // loop_control_reg
  localparam logic [3:0] PMLC_BW_OFF    = 4'h1; // bandwidth control
  localparam logic [3:0] PMLC_MULT_OFF  = 4'h2; // loop_multiplier_select
  // control register bit positions
  localparam int PMLC_IE_BIT   = 7;
  localparam int PMLC_CF_BIT   = 6;
  localparam int PMLC_ON_BIT   = 5;
  localparam int PMLC_SEL_BIT  = 4;
  // bandwidth register bit positions
  localparam int PMLC_AUTO_BIT = 7;
  localparam int PMLC_LOCK_BIT = 6;
  localparam int PMLC_TRK_BIT  = 5;
  // multiplier field positions
  localparam int PMLC_N_LSB    = 4;
  localparam int PMLC_L_LSB    = 0;
  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic       PMLC_ON_RST   = 1'b1; // loop on from reset
  localparam logic       PMLC_AUTO_RST = 1'b0;
  localparam logic [7:0] PMLC_MULT_RST = 8'h00;
  // ****************************************************************
  // window length in reference edges, and frequencies in Hz
  // ****************************************************************
  localparam logic [7:0] PMLC_WIN_RST  = 8'h10; // reference window
  localparam int PMLC_FNOM_HZ = 4915200; // nominal center frequency
  localparam int PMLC_CLK_HZ  = 200000000;
  // filter mode encoding seen by the analog loop filter
  typedef enum logic { PMLC_ACQUIRE, PMLC_TRACK } pmlc_mode_t;
endpackage : pmlc_pkg

// *** inc/pmlc_cnt_if.sv ***
// interface: feedback divider to lock detector
// assumes: both ends on sys_clk
interface pmlc_cnt_if;
  logic fb_pulse; // one pulse per divided feedback period
  modport div (output fb_pulse);
  modport det (input  fb_pulse);
endinterface : pmlc_cnt_if

// *** hdl/pmlc_divider.sv ***
// feedback modulo divider: one pulse every n vco edges
// assumes: vco edge already synchronised to sys_clk
module pmlc_divider
  import pmlc_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       vco_edge,
  input  wire logic [3:0] factor,
  pmlc_cnt_if.div         fb
);
  typedef struct packed {
    logic [3:0] cnt;   // vco edges so far
    logic       pulse; // divided output pulse
  } pmlc_div_st_t;
  pmlc_div_st_t st_r;
  pmlc_div_st_t st_nxt;
  logic [3:0]   div_n; // effective divide factor
  // ****************************************************************
  // divide logic
  // ****************************************************************
  always_comb begin
    // [R19] zero same as one
    div_n = (factor == 4'h0) ? 4'h1 : factor;
    st_nxt = st_r;
    st_nxt.pulse = 1'b0;
    // [R14] modulo n divide
    if (vco_edge) begin
      if (st_r.cnt + 4'h1 >= div_n) begin
        st_nxt.cnt = 4'h0;
        st_nxt.pulse = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt + 4'h1;
      end
    end
  end
  // state register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign fb.fb_pulse = st_r.pulse;
  // [R14] pulse only after edge
  div_pulse_a: assert property (@(posedge sys_clk) disable iff (rst)
    st_r.pulse |-> $past(vco_edge)) // [R14]
    else $error("divider pulse without vco edge");
endmodule : pmlc_divider

// *** hdl/pmlc_detector.sv ***
// lock detector: counts feedback pulses per reference window
// assumes: reference edge synchronised, feedback pulse on sys_clk
module pmlc_detector
  import pmlc_pkg::*;
#(
  parameter logic [7:0] WIN     = PMLC_WIN_RST,
  parameter logic [7:0] TRK_TOL = 8'h02,
  parameter logic [7:0] UNT_TOL = 8'h04,
  parameter logic [7:0] LCK_TOL = 8'h01,
  parameter logic [7:0] UNL_TOL = 8'h03
)(
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic enable,
  input  wire logic ref_edge,
  pmlc_cnt_if.det   fb,
  output      logic near_trk,
  output      logic near_lock
);
  typedef struct packed {
    logic [7:0] refs;  // reference edges in window
    logic [7:0] fbs;   // feedback pulses in window
    logic       trk;
    logic       lock;
  } pmlc_det_st_t;
  pmlc_det_st_t st_r;
  pmlc_det_st_t st_nxt;
  logic [7:0]   diff;
  // ****************************************************************
  // window compare at reference rate
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    diff = (st_r.fbs > WIN) ? st_r.fbs - WIN : WIN - st_r.fbs;
    if (!enable) begin
      st_nxt = '0;
    end else begin
      if (fb.fb_pulse && st_r.fbs != 8'hff) begin
        st_nxt.fbs = st_r.fbs + 8'h01;
      end
      // [R17] evaluated per reference edge
      if (ref_edge) begin
        if (st_r.refs + 8'h01 >= WIN) begin
          st_nxt.refs = 8'h00;
          st_nxt.fbs = {7'h00, fb.fb_pulse};
          // hysteresis: enter inside tight band, leave past loose one
          if (diff <= TRK_TOL) st_nxt.trk = 1'b1;
          else if (diff > UNT_TOL) st_nxt.trk = 1'b0;
          if (diff <= LCK_TOL) st_nxt.lock = 1'b1;
          else if (diff > UNL_TOL) st_nxt.lock = 1'b0;
        end else begin
          st_nxt.refs = st_r.refs + 8'h01;
        end
      end
    end
  end
  // state register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign near_trk  = st_r.trk;
  assign near_lock = st_r.lock;
  // [R17] lock changes only on a reference edge or when the detector is disabled
  lock_ref_a: assert property (@(posedge sys_clk) disable iff (rst)
    $changed(st_r.lock) |-> $past(ref_edge) || !$past(enable)) // [R17]
    else $error("lock changed off reference edge");
endmodule : pmlc_detector

// *** hdl/pmlc_top.sv ***
// top of the loop mode and lock control: registers, mode choice, flags
// assumes: vco_clk and buffered_ref_clk arrive as pins from the analog
// side and are sampled; software uses the plain register port
//
// Function
// [R1] acquisition mode keeps track bit clear
// [R2] tracking mode whenever not acquiring
// [R3] auto mode: detector switches filter mode
// [R4] auto mode: track bit read-only status
// [R5] track set in tolerance, cleared outside
// [R6] in-range flag follows lock tolerances
// [R7] interrupt enable passes toggles to request
// [R8] manual mode: track bit software written
// [R9] software clears track before loop on
// [R10] software waits acquisition time before track
// [R11] software waits lock time before select
// [R12] manual mode: no lock, no interrupt
// [R13] multiplier: n upper, range lower nibble
// [R14] feedback divided by multiplier factor
// [R15] reference used undivided
// [R16] center is range times nominal frequency
// [R17] lock compares frequencies at reference rate
// [R18] software selects vco only after lock
// [R19] multiplier zero acts as one
// [R20] range zero disables loop and selection
// [R21] change flag set on toggle, read clears
// [R22] multiplier read-only while loop on
// [R23] tolerances and waits are parameters
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
module pmlc_top
  import pmlc_pkg::*;
#(
  // [R23] windows and bands tunable
  // window length in reference edges
  parameter logic [7:0] WIN     = PMLC_WIN_RST,
  // track band: enter at or below
  parameter logic [7:0] TRK_TOL = 8'h02,
  // track band: leave above
  parameter logic [7:0] UNT_TOL = 8'h04,
  // lock band: enter at or below
  parameter logic [7:0] LCK_TOL = 8'h01,
  // lock band: leave above
  parameter logic [7:0] UNL_TOL = 8'h03
)(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output      logic [7:0]  reg_rdata,
  input  wire logic        buffered_ref_clk,
  input  wire logic        vco_clk,
  output      logic        final_ref_edge,
  output      logic        vco_feedback_pulse,
  output      logic        filter_mode,
  output      logic        loop_power_on,
  output      logic        base_source_vco,
  output      logic [3:0]  vco_range,
  output      logic [25:0] vco_center_khz,
  output      logic        loop_irq
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [2:0] ref_s;   // reference sync and edge history
    logic [2:0] vco_s;   // vco sync and edge history
    logic       ie;      // loop_irq_enable
    logic       cf;      // loop_change_flag
    logic       on;      // loop_power_enable
    logic       sel;     // base_source_select
    logic       auto_bw; // bandwidth_self_select
    logic       trk_sw;  // manual filter_track_select
    logic       lock_q;  // last lock, for toggle detect
    logic [7:0] mult;    // loop_multiplier_select
    logic [7:0] rdata;   // read data, one cycle after strobe
  } pmlc_st_t;
  pmlc_st_t   st_r;
  pmlc_st_t   st_nxt;
  pmlc_cnt_if fb_if ();
  logic       ref_edge;   // rising reference edge, synchronised
  logic       vco_edge;   // rising vco edge, synchronised
  logic       det_trk;    // detector says within tracking band
  logic       det_lock;   // detector says locked
  logic       lock_vis;   // lock as seen by software
  logic       trk_now;    // current filter track bit
  logic       range_ok;   // range factor nonzero
  logic       loop_run;   // loop truly enabled
  logic [7:0] ctrl_rd;    // control register as read
  logic [7:0] bw_rd;      // bandwidth register as read

  // pins are far slower than sys_clk, so a short history
  // sees every rising edge; a faster vco would alias
  // bit 0 of each sync chain feeds only bit 1
  assign ref_edge = st_r.ref_s[1] & ~st_r.ref_s[2];
  assign vco_edge = st_r.vco_s[1] & ~st_r.vco_s[2];
  // [R20] range zero disables loop
  assign range_ok = (st_r.mult[PMLC_L_LSB +: 4] != 4'h0);
  assign loop_run = st_r.on & range_ok;
  // [R12] lock hidden in manual mode
  assign lock_vis = st_r.auto_bw & det_lock;
  // [R3] detector drives mode in auto
  assign trk_now = st_r.auto_bw ? det_trk : st_r.trk_sw;

  // ****************************************************************
  // submodules
  // ****************************************************************
  // divider sees vco edges only while the loop runs,
  // so a stopped loop freezes the feedback count
  pmlc_divider u_div (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .vco_edge (vco_edge & loop_run),
    .factor   (st_r.mult[PMLC_N_LSB +: 4]),
    .fb       (fb_if)
  );
  // [R15] reference edge straight to detector
  pmlc_detector #(
    .WIN     (WIN),
    .TRK_TOL (TRK_TOL),
    .UNT_TOL (UNT_TOL),
    .LCK_TOL (LCK_TOL),
    .UNL_TOL (UNL_TOL)
  ) u_det (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .enable    (loop_run),
    .ref_edge  (ref_edge),
    .fb        (fb_if),
    .near_trk  (det_trk),
    .near_lock (det_lock)
  );

  // ****************************************************************
  // read views
  // ****************************************************************
  always_comb begin
    ctrl_rd = 8'h00;
    // [R12] enable reads zero in manual
    ctrl_rd[PMLC_IE_BIT]  = st_r.ie & st_r.auto_bw;
    ctrl_rd[PMLC_CF_BIT]  = st_r.cf & st_r.auto_bw;
    ctrl_rd[PMLC_ON_BIT]  = st_r.on;
    ctrl_rd[PMLC_SEL_BIT] = st_r.sel;
    bw_rd = 8'h00;
    bw_rd[PMLC_AUTO_BIT] = st_r.auto_bw;
    // [R6] in-range flag from detector
    bw_rd[PMLC_LOCK_BIT] = lock_vis;
    // [R4] track bit shows mode
    bw_rd[PMLC_TRK_BIT]  = trk_now;
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.ref_s = {st_r.ref_s[1:0], buffered_ref_clk};
    st_nxt.vco_s = {st_r.vco_s[1:0], vco_clk};
    // toggles in manual mode are swallowed by the
    // forced clear below
    st_nxt.lock_q = lock_vis;
    // read data idle at zero outside the answer cycle
    st_nxt.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        PMLC_CTRL_OFF: st_nxt.rdata = ctrl_rd;
        PMLC_BW_OFF:   st_nxt.rdata = bw_rd;
        PMLC_MULT_OFF: st_nxt.rdata = st_r.mult;
        default:       st_nxt.rdata = 8'h00; // unmapped reads zero
      endcase
      // [R21] read of control clears flag
      if (reg_addr == PMLC_CTRL_OFF) st_nxt.cf = 1'b0;
    end
    if (reg_wr) begin
      case (reg_addr)
        PMLC_CTRL_OFF: begin
          // enable only writable in auto mode
          if (st_r.auto_bw) st_nxt.ie = reg_wdata[PMLC_IE_BIT];
          // loop cannot drop while vco drives the base clock,
          // nor change together with the select bit
          if (!st_r.sel && !reg_wdata[PMLC_SEL_BIT])
            st_nxt.on = reg_wdata[PMLC_ON_BIT];
          // [R20] select only with loop on and range
          if (loop_run && (st_r.on == reg_wdata[PMLC_ON_BIT]))
            st_nxt.sel = reg_wdata[PMLC_SEL_BIT];
        end
        PMLC_BW_OFF: begin
          st_nxt.auto_bw = reg_wdata[PMLC_AUTO_BIT];
          // [R8] manual writes steer filter
          if (!st_r.auto_bw) st_nxt.trk_sw = reg_wdata[PMLC_TRK_BIT];
        end
        PMLC_MULT_OFF: begin
          // both nibbles land together, never half
          // [R22] ignored while loop on
          if (!st_r.on) st_nxt.mult = reg_wdata;
        end
        default: ;
      endcase
    end
    // [R21] toggle sets flag, wins over clear
    if (lock_vis != st_r.lock_q) st_nxt.cf = 1'b1;
    if (!st_r.auto_bw) begin
      st_nxt.ie = 1'b0;
      st_nxt.cf = 1'b0;
    end
    // [R20] range zero forces crystal source
    if (!range_ok) st_nxt.sel = 1'b0;
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r <= '0;
      st_r.on <= PMLC_ON_RST;
      st_r.auto_bw <= PMLC_AUTO_RST;
      st_r.mult <= PMLC_MULT_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign reg_rdata = st_r.rdata;
  assign final_ref_edge = ref_edge;
  assign vco_feedback_pulse = fb_if.fb_pulse;
  // [R1] [R2] clear bit means acquire
  assign filter_mode = trk_now ? PMLC_TRACK : PMLC_ACQUIRE;
  assign loop_power_on = loop_run;
  // select is also masked by range, so a range of
  // zero drops the vco source at once
  assign base_source_vco = st_r.sel & range_ok;
  // [R13] range in lower nibble
  assign vco_range = st_r.mult[PMLC_L_LSB +: 4];
  // [R16] center = range times nominal
  assign vco_center_khz = 26'(vco_range * (PMLC_FNOM_HZ / 1000));
  // [R7] flag gated by enable
  assign loop_irq = st_r.cf & st_r.ie & st_r.auto_bw;

  // ****************************************************************
  // checks
  // ****************************************************************
  // [R7] toggle raises request
  irq_toggle_a: assert property (@(posedge sys_clk) disable iff (rst)
    (st_r.auto_bw && st_r.ie && $changed(st_r.lock_q) && !reg_wr
     && $stable(st_r.auto_bw)) |-> loop_irq) // [R7]
    else $error("lock toggle did not raise request");

  // [R12] manual mode silent
  manual_quiet_a: assert property (@(posedge sys_clk) disable iff (rst)
    !st_r.auto_bw |-> !loop_irq && !bw_rd[PMLC_LOCK_BIT]) // [R12]
    else $error("manual mode shows lock or request");

  // [R22] multiplier frozen
  mult_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    st_r.on |=> $stable(st_r.mult)) // [R22]
    else $error("multiplier changed while loop on");

  // [R21] read clears flag
  flag_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
    (reg_rd && reg_addr == PMLC_CTRL_OFF && lock_vis == st_r.lock_q)
    |=> !st_r.cf) // [R21]
    else $error("control read left change flag set");

  // [R4] auto ignores track writes
  trk_ro_a: assert property (@(posedge sys_clk) disable iff (rst)
    st_r.auto_bw |=> $stable(st_r.trk_sw)) // [R4]
    else $error("track bit written in auto mode");

  // [R20] no vco select without range
  range_sel_a: assert property (@(posedge sys_clk) disable iff (rst)
    !range_ok |-> !base_source_vco && !loop_power_on) // [R20]
    else $error("range zero yet loop active");

  // [R5] mode follows detector
  auto_mode_a: assert property (@(posedge sys_clk) disable iff (rst)
    st_r.auto_bw |-> (filter_mode == det_trk)) // [R5]
    else $error("auto filter mode off detector");

  // [R8] manual write lands
  man_write_a: assert property (@(posedge sys_clk) disable iff (rst)
    (!st_r.auto_bw && reg_wr && reg_addr == PMLC_BW_OFF)
    |=> st_r.trk_sw == $past(reg_wdata[PMLC_TRK_BIT])) // [R8]
    else $error("manual track write lost");

  // [R20] vco source needs running loop
  sel_run_a: assert property (@(posedge sys_clk) disable iff (rst)
    base_source_vco |-> loop_power_on) // [R20]
    else $error("vco source without running loop");

  // [R8] manual mode follows software bit
  man_mode_a: assert property (@(posedge sys_clk) disable iff (rst)
    !st_r.auto_bw |-> (filter_mode == st_r.trk_sw)) // [R8]
    else $error("manual filter mode off software bit");

  // [R21] toggle sets flag, beats clear
  flag_set_a: assert property (@(posedge sys_clk) disable iff (rst)
    (st_r.auto_bw && lock_vis != st_r.lock_q) |=> st_r.cf) // [R21]
    else $error("lock toggle left change flag clear");
endmodule : pmlc_top

// *** tb/pmlc_loop_model.sv ***
// partner: free-running reference crystal and the analog vco behind pins
// assumes: bench hands over the feedback factor and a detune knob
module pmlc_loop_model #(
  parameter real REF_HALF_NS = 200.0 // reference half period, slow pin
)(
  input  wire logic       loop_power_on,
  input  wire logic [3:0] mult_n,
  input  wire logic       detune,
  output      logic       buffered_ref_clk,
  output      logic       vco_clk
);
  timeunit 1ns;
  timeprecision 100ps;

  real vco_half; // current vco half period

  // ****************************************************************
  // reference crystal
  // ****************************************************************
  // crystal runs free from time zero, loop or no loop
  initial begin
    buffered_ref_clk = 1'b0;
    forever #(REF_HALF_NS) buffered_ref_clk = ~buffered_ref_clk;
  end

  // ****************************************************************
  // vco
  // ****************************************************************
  // vco at n times reference
  initial begin
    vco_clk = 1'b0;
    forever begin
      if (loop_power_on !== 1'b1) begin
        // a dead oscillator holds low instead of ticking on
        vco_clk = 1'b0;
        @(loop_power_on);
      end else begin
        vco_half = REF_HALF_NS / ((mult_n == 4'h0) ? 1.0 : real'(mult_n));
        // detune doubles the rate, far outside every tolerance
        if (detune) vco_half = vco_half / 2.0;
        #(vco_half) vco_clk = ~vco_clk;
      end
    end
  end
endmodule : pmlc_loop_model

// *** tb/pmlc_top_tb.sv ***
// bench: register traffic, manual and automatic filter modes, lock flags
// assumes: partner model supplies reference and vco pins
module pmlc_top_tb
  import pmlc_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;

  localparam int T_WAIT = 200; // software settle waits, cycles

  logic        sys_clk;            // 200 MHz
  logic        rst;                // sync, high
  logic [3:0]  reg_addr;           // register port
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        buffered_ref_clk;   // from partner
  logic        vco_clk;
  logic        final_ref_edge;     // design outputs
  logic        vco_feedback_pulse;
  logic        filter_mode;
  logic        loop_power_on;
  logic        base_source_vco;
  logic [3:0]  vco_range;
  logic [25:0] vco_center_khz;
  logic        loop_irq;
  logic [3:0]  mult_n;             // factor told to the partner
  logic        detune;             // partner off frequency
  logic [7:0]  v;                  // random data
  logic [3:0]  a;                  // random unmapped address
  int          nr;                 // reference edges counted
  int          nf;                 // feedback pulses counted
  int          num_errors;
  int          n_checks;

  // small window keeps each lock decision short
  pmlc_top #(.WIN(8'h04), .TRK_TOL(8'h01), .UNT_TOL(8'h02),
             .LCK_TOL(8'h01), .UNL_TOL(8'h02)) pmlc_top_inst (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .buffered_ref_clk(buffered_ref_clk),
    .vco_clk(vco_clk), .final_ref_edge(final_ref_edge),
    .vco_feedback_pulse(vco_feedback_pulse), .filter_mode(filter_mode),
    .loop_power_on(loop_power_on), .base_source_vco(base_source_vco),
    .vco_range(vco_range), .vco_center_khz(vco_center_khz),
    .loop_irq(loop_irq));

  pmlc_loop_model pmlc_loop_model_inst (
    .loop_power_on(loop_power_on), .mult_n(mult_n), .detune(detune),
    .buffered_ref_clk(buffered_ref_clk), .vco_clk(vco_clk));

  // ****************************************************************
  // clock, watchdog, verdict
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // limit is about seven times the expected run
  initial begin
    #250000;
    num_errors++;
    report_and_stop();
  end

  task automatic report_and_stop();
    if (num_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  // ****************************************************************
  // compares and bus cycles
  // ****************************************************************
  task automatic check_reg(input string n, input logic [7:0] e,
                           input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : check_reg

  task automatic check_bit(input string n, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %b seen %b", n, e, g);
    end
  endtask : check_bit

  task automatic wr(input logic [3:0] ad, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= ad;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] ad, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= ad;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic rd_check(input logic [3:0] ad, input logic [7:0] e,
                          input string n);
    logic [7:0] d;
    rd(ad, d);
    check_reg(n, e, d);
  endtask : rd_check

  // writes land next cycle; give outputs a few edges
  task automatic settle();
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : settle

  // polls the bandwidth register, which never clears the change flag
  task automatic wait_lock(input logic want);
    logic [7:0] d;
    for (int i = 0; i < 1500; i++) begin
      rd(PMLC_BW_OFF, d);
      if (d[PMLC_LOCK_BIT] === want) break;
      repeat (4) @(posedge sys_clk);
    end
  endtask : wait_lock

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    rst = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    mult_n = 4'h0;
    detune = 1'b0;
    num_errors = 0;
    n_checks = 0;
    void'($urandom(96577));
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    // reset state, range zero keeps loop and select off
    rd_check(PMLC_CTRL_OFF, 8'h20, "ctrl reset");
    rd_check(PMLC_BW_OFF, 8'h00, "bw reset");
    rd_check(PMLC_MULT_OFF, PMLC_MULT_RST, "mult reset");
    check_bit("power out", 1'b0, loop_power_on);
    wr(PMLC_CTRL_OFF, 8'h30);
    settle();
    check_bit("select range zero", 1'b0, base_source_vco);
    // random refused multiplier writes and unmapped places
    for (int i = 0; i < 6; i++) begin
      v = 8'($urandom);
      a = 4'(3 + $urandom_range(12));
      wr(PMLC_MULT_OFF, v);
      rd_check(PMLC_MULT_OFF, 8'h00, "mult while on");
      wr(a, v);
      rd_check(a, 8'h00, "unmapped");
    end
    // program n=2, l=3 with the loop off, track clear before power on
    wr(PMLC_CTRL_OFF, 8'h00);
    wr(PMLC_MULT_OFF, 8'h23);
    rd_check(PMLC_MULT_OFF, 8'h23, "mult");
    settle();
    check_reg("range", 8'h03, {4'h0, vco_range});
    check_bit("center", 1'b1, vco_center_khz === 26'd14745);
    mult_n <= 4'h2;
    wr(PMLC_CTRL_OFF, 8'h20);
    settle();
    check_bit("power on", 1'b1, loop_power_on);
    // manual mode: software owns the track bit
    repeat (T_WAIT) @(posedge sys_clk);
    wr(PMLC_BW_OFF, 8'h20);
    rd_check(PMLC_BW_OFF, 8'h20, "manual track");
    check_bit("mode track", 1'b1, filter_mode);
    repeat (T_WAIT) @(posedge sys_clk);
    wr(PMLC_CTRL_OFF, 8'h30);
    settle();
    check_bit("manual select", 1'b1, base_source_vco);
    wr(PMLC_CTRL_OFF, 8'ha0);
    rd_check(PMLC_CTRL_OFF, 8'h20, "manual irq enable");
    wr(PMLC_BW_OFF, 8'h00);
    settle();
    check_bit("mode acquire", 1'b0, filter_mode);
    repeat (2000) @(posedge sys_clk);
    rd_check(PMLC_BW_OFF, 8'h00, "manual no lock");
    check_bit("manual irq", 1'b0, loop_irq);
    // automatic mode: detector takes over
    wr(PMLC_BW_OFF, 8'h80);
    wr(PMLC_CTRL_OFF, 8'ha0);
    wait_lock(1'b1);
    rd_check(PMLC_BW_OFF, 8'he0, "auto locked");
    check_bit("auto track", 1'b1, filter_mode);
    check_bit("irq on lock", 1'b1, loop_irq);
    wr(PMLC_BW_OFF, 8'h80);
    rd_check(PMLC_BW_OFF, 8'he0, "track read only");
    rd_check(PMLC_CTRL_OFF, 8'he0, "flag set");
    rd_check(PMLC_CTRL_OFF, 8'ha0, "flag cleared");
    check_bit("irq cleared", 1'b0, loop_irq);
    // feedback rate matches the undivided reference once locked
    nr = 0;
    nf = 0;
    repeat (4000) begin
      @(posedge sys_clk);
      #1;
      nr += int'(final_ref_edge);
      nf += int'(vco_feedback_pulse);
    end
    check_bit("ref rate", 1'b1, nr >= 49 && nr <= 51);
    check_bit("fb rate", 1'b1, nf - nr <= 1 && nr - nf <= 1);
    // select vco, then lose lock and react
    wr(PMLC_CTRL_OFF, 8'hb0);
    settle();
    check_bit("select vco", 1'b1, base_source_vco);
    detune <= 1'b1;
    wait_lock(1'b0);
    rd_check(PMLC_BW_OFF, 8'h80, "auto unlocked");
    check_bit("back to acquire", 1'b0, filter_mode);
    check_bit("irq on unlock", 1'b1, loop_irq);
    wr(PMLC_CTRL_OFF, 8'ha0);
    settle();
    check_bit("deselect", 1'b0, base_source_vco);
    rd_check(PMLC_CTRL_OFF, 8'he0, "flag unlock");
    // n of zero must lock with vco at the reference rate
    detune <= 1'b0;
    wr(PMLC_CTRL_OFF, 8'h80);
    wr(PMLC_MULT_OFF, 8'h05);
    mult_n <= 4'h0;
    wr(PMLC_CTRL_OFF, 8'ha0);
    settle();
    check_bit("center 5", 1'b1, vco_center_khz === 26'd24575);
    wait_lock(1'b1);
    rd_check(PMLC_BW_OFF, 8'he0, "n zero locks");
    // masking leaves the flag but drops the request
    wr(PMLC_CTRL_OFF, 8'h20);
    settle();
    check_bit("irq masked", 1'b0, loop_irq);
    rd_check(PMLC_CTRL_OFF, 8'h60, "flag kept");
    report_and_stop();
  end
endmodule : pmlc_top_tb
